/* rtl/micf_top.sv */
// How it works
// - one control byte per each of 25 sources
// - two-bit level per source, level 0 highest
// - equal levels resolve by fixed rank 0 first
// - level bits writable, reset to lowest level
// - context select tells core to switch bank
// - macro select picks hardware transfer servicing
// - macro end clears that source's macro select
// - macro select resets clear, software writable
// - set mask blocks vectored and macro requests
// - mask untouched by service, mirrored in mask registers
// - mask writable, reset sets every mask
// - request flag set by request, cleared on acknowledge
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
module micf_top
  import micf_pkg::*;
(
  input wire logic REF_CLK, // system clock, 10 MHz
  input wire logic ARST_N, // async reset, active low
  input wire logic HSEL, // ahb slave select
  input wire logic [ADDR_W-1:0] HADDR, // ahb byte address
  input wire logic [1:0] HTRANS, // ahb transfer type
  input wire logic HWRITE, // ahb write strobe
  input wire logic [2:0] HSIZE, // ahb transfer size
  input wire logic [31:0] HWDATA, // ahb write data
  input wire logic HREADY, // ahb bus ready
  output logic HREADYOUT, // ahb slave ready
  output logic HRESP, // ahb response, always okay
  output logic [31:0] HRDATA, // ahb read data
  input wire logic [NSRC-1:0] SRC_REQ, // peripheral and pin requests
  output logic INT_VALID, // a request awaits acknowledge
  output logic [ID_W-1:0] INT_ID, // rank of the offered source
  output logic [1:0] INT_LEVEL, // its programmed level
  output logic INT_MACRO, // service by macro transfer
  output logic INT_CTX, // service by context switching
  input wire logic INT_ACK, // core takes the offered request
  input wire logic MACRO_END, // macro counter of a source hit zero
  input wire logic [ID_W-1:0] MACRO_END_ID, // source whose macro ended
  output logic IRQ // event interrupt, level
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [NSRC-1:0] if_q;
  logic [NSRC-1:0] mk_q;
  logic [NSRC-1:0] ism_q;
  logic [NSRC-1:0] cse_q;
  logic [NSRC-1:0][1:0] pr_q;
  logic [NSRC-1:0] req_rise;
  logic ap_wr_q;
  logic [ADDR_W-1:0] ap_addr_q;
  logic ap_take;
  logic dp_wr;
  logic [31:0] rdata_q;
  logic [EV_W-1:0] ev_stat_q;
  logic [EV_W-1:0] ev_en_q;
  logic [EV_W-1:0] ev_set;
  logic valid_q;
  logic [ID_W-1:0] id_q;
  logic [1:0] lvl_q;
  logic macro_q;
  logic ctx_q;
  logic ack_take;

  micf_arb_if arb_bus ();

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic ctrl_hit(input logic [ADDR_W-1:0] a);
    return (a >= CTRL_BASE_OFS) && (a <= CTRL_LAST_OFS) && (a[1:0] == 2'h0);
  endfunction : ctrl_hit

  function automatic logic [ID_W-1:0] ctrl_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = (a - CTRL_BASE_OFS) >> 2;
    return d[ID_W-1:0];
  endfunction : ctrl_idx

  function automatic logic [7:0] ctrl_byte(input int i, input logic fi, input logic fm,
                                           input logic fs, input logic fc,
                                           input logic [1:0] fp);
    logic [7:0] b;
    b = 8'h00;
    b[IF_BIT] = fi;
    b[MK_BIT] = fm;
    b[ISM_BIT] = fs & ISM_PRESENT[i];
    b[CSE_BIT] = fc;
    b[PR_HI_BIT] = fp[1];
    b[PR_LO_BIT] = fp[0];
    return b;
  endfunction : ctrl_byte

  // ---------------------------------------------------------------
  // request capture
  // ---------------------------------------------------------------
  micf_req_sync #(
    .W(NSRC)
  ) u_sync (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .req_in(SRC_REQ),
    .req_rise(req_rise)
  );

  // ---------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ---------------------------------------------------------------
  assign ap_take = HSEL && HTRANS[1] && HREADY;
  assign dp_wr = ap_wr_q;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_q;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ap_wr_q <= 1'b0;
      ap_addr_q <= '0;
    end else begin
      ap_wr_q <= ap_take && HWRITE;
      if (ap_take) begin
        ap_addr_q <= HADDR;
      end
    end
  end

  // read data is sampled at the address phase, so a write in the
  // preceding data phase is not yet visible to a read right behind it
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_q <= '0;
    end else if (ap_take && !HWRITE) begin
      rdata_q <= '0;
      if (ctrl_hit(HADDR)) begin
        for (int i = 0; i < NSRC; i++) begin
          if (ctrl_idx(HADDR) == ID_W'(i)) begin
            rdata_q[7:0] <= ctrl_byte(i, if_q[i], mk_q[i], ism_q[i], cse_q[i], pr_q[i]);
          end
        end
      end else if (HADDR == MASK_LO_OFS) begin
        rdata_q[MASK_LO_W-1:0] <= mk_q[MASK_LO_W-1:0];
      end else if (HADDR == MASK_HI_OFS) begin
        rdata_q[MASK_HI_W-1:0] <= mk_q[NSRC-1:MASK_LO_W];
      end else if (HADDR == EV_STAT_OFS) begin
        rdata_q[EV_W-1:0] <= ev_stat_q;
      end else if (HADDR == EV_EN_OFS) begin
        rdata_q[EV_W-1:0] <= ev_en_q;
      end else if (HADDR == SVC_STAT_OFS) begin
        rdata_q[SVC_VALID_BIT] <= valid_q;
        rdata_q[SVC_MACRO_BIT] <= macro_q;
        rdata_q[SVC_CTX_BIT] <= ctx_q;
        rdata_q[SVC_LVL_LSB +: 2] <= lvl_q;
        rdata_q[SVC_ID_LSB +: ID_W] <= id_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // request flags
  // ---------------------------------------------------------------
  assign ack_take = INT_ACK && valid_q;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      if_q <= {NSRC{IF_RST}};
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        if (req_rise[i]) begin
          if_q[i] <= 1'b1;
        end else if (dp_wr && ctrl_hit(ap_addr_q) && ctrl_idx(ap_addr_q) == ID_W'(i)) begin
          if_q[i] <= HWDATA[IF_BIT];
        end else if (ack_take && id_q == ID_W'(i)) begin
          if_q[i] <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // mask flags, one store shared by control bytes and mask words
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mk_q <= {NSRC{MK_RST}};
    end else if (dp_wr) begin
      if (ap_addr_q == MASK_LO_OFS) begin
        mk_q[MASK_LO_W-1:0] <= HWDATA[MASK_LO_W-1:0];
      end else if (ap_addr_q == MASK_HI_OFS) begin
        mk_q[NSRC-1:MASK_LO_W] <= HWDATA[MASK_HI_W-1:0];
      end else if (ctrl_hit(ap_addr_q)) begin
        for (int i = 0; i < NSRC; i++) begin
          if (ctrl_idx(ap_addr_q) == ID_W'(i)) begin
            mk_q[i] <= HWDATA[MK_BIT];
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // macro service select
  // ---------------------------------------------------------------
  // a software write in the same cycle as a macro end takes precedence
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ism_q <= {NSRC{ISM_RST}};
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        if (dp_wr && ctrl_hit(ap_addr_q) && ctrl_idx(ap_addr_q) == ID_W'(i)) begin
          ism_q[i] <= HWDATA[ISM_BIT] & ISM_PRESENT[i];
        end else if (MACRO_END && MACRO_END_ID == ID_W'(i)) begin
          ism_q[i] <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // context select and level bits
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cse_q <= {NSRC{CSE_RST}};
      pr_q <= {NSRC{PR_RST}};
    end else if (dp_wr && ctrl_hit(ap_addr_q)) begin
      for (int i = 0; i < NSRC; i++) begin
        if (ctrl_idx(ap_addr_q) == ID_W'(i)) begin
          cse_q[i] <= HWDATA[CSE_BIT];
          pr_q[i] <= {HWDATA[PR_HI_BIT], HWDATA[PR_LO_BIT]};
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // selection
  // ---------------------------------------------------------------
  assign arb_bus.elig = if_q & ~mk_q;
  assign arb_bus.lvl = pr_q;

  micf_arbiter u_arb (
    .arb(arb_bus.arb)
  );

  // offer is registered; the cycle after an acknowledge shows no offer so
  // the core never sees the old winner while its flag is clearing
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      valid_q <= 1'b0;
      id_q <= '0;
      lvl_q <= PR_RST;
      macro_q <= 1'b0;
      ctx_q <= 1'b0;
    end else begin
      valid_q <= arb_bus.win_valid && !ack_take;
      id_q <= arb_bus.win_id;
      lvl_q <= arb_bus.win_lvl;
      macro_q <= ism_q[arb_bus.win_id];
      ctx_q <= cse_q[arb_bus.win_id] && !ism_q[arb_bus.win_id];
    end
  end

  assign INT_VALID = valid_q;
  assign INT_ID = id_q;
  assign INT_LEVEL = lvl_q;
  assign INT_MACRO = macro_q;
  assign INT_CTX = ctx_q;

  // ---------------------------------------------------------------
  // event interrupt
  // ---------------------------------------------------------------
  assign ev_set = {MACRO_END, ack_take};

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ev_stat_q <= EV_RST;
    end else if (dp_wr && ap_addr_q == EV_CLR_OFS) begin
      ev_stat_q <= (ev_stat_q & ~HWDATA[EV_W-1:0]) | ev_set;
    end else begin
      ev_stat_q <= ev_stat_q | ev_set;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ev_en_q <= EV_RST;
    end else if (dp_wr && ap_addr_q == EV_EN_OFS) begin
      ev_en_q <= HWDATA[EV_W-1:0];
    end
  end

  assign IRQ = |(ev_stat_q & ev_en_q);
endmodule : micf_top

/* rtl/micf_pkg.sv */
package micf_pkg;
  // ---------------------------------------------------------------
  // source count and control byte layout
  // ---------------------------------------------------------------
  localparam int NSRC = 25;
  localparam int ID_W = 5;
  localparam int ADDR_W = 12;
  localparam int IF_BIT = 7;
  localparam int MK_BIT = 6;
  localparam int ISM_BIT = 5;
  localparam int CSE_BIT = 4;
  localparam int PR_HI_BIT = 1;
  localparam int PR_LO_BIT = 0;
  localparam logic [1:0] PR_RST = 2'h3;
  localparam logic IF_RST = 1'b0;
  localparam logic MK_RST = 1'b1;
  localparam logic ISM_RST = 1'b0;
  localparam logic CSE_RST = 1'b0;
  // sources 14 and 18 (serial error requests) have no macro service select
  localparam logic [NSRC-1:0] ISM_PRESENT = 25'h1FBBFFF;
  localparam int MASK_LO_W = 16;
  localparam int MASK_HI_W = NSRC - MASK_LO_W;

  // ---------------------------------------------------------------
  // byte offsets on the register bus
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTRL_BASE_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] CTRL_LAST_OFS = 12'h060;
  localparam logic [ADDR_W-1:0] MASK_LO_OFS = 12'h080;
  localparam logic [ADDR_W-1:0] MASK_HI_OFS = 12'h084;
  localparam logic [ADDR_W-1:0] EV_STAT_OFS = 12'h090;
  localparam logic [ADDR_W-1:0] EV_CLR_OFS = 12'h094;
  localparam logic [ADDR_W-1:0] EV_EN_OFS = 12'h098;
  localparam logic [ADDR_W-1:0] SVC_STAT_OFS = 12'h09C;

  // ---------------------------------------------------------------
  // event status bits
  // ---------------------------------------------------------------
  localparam int EV_W = 2;
  localparam int EV_ACK_BIT = 0;
  localparam int EV_MEND_BIT = 1;
  localparam logic [EV_W-1:0] EV_RST = 2'h0;

  // ---------------------------------------------------------------
  // service status word layout
  // ---------------------------------------------------------------
  localparam int SVC_VALID_BIT = 31;
  localparam int SVC_MACRO_BIT = 9;
  localparam int SVC_CTX_BIT = 8;
  localparam int SVC_LVL_LSB = 5;
  localparam int SVC_ID_LSB = 0;
endpackage : micf_pkg

/* rtl/micf_arb_if.sv */
interface micf_arb_if
  import micf_pkg::*;
  ();
  logic [NSRC-1:0] elig;
  logic [NSRC-1:0][1:0] lvl;
  logic win_valid;
  logic [ID_W-1:0] win_id;
  logic [1:0] win_lvl;

  modport req (output elig, output lvl, input win_valid, input win_id, input win_lvl);
  modport arb (input elig, input lvl, output win_valid, output win_id, output win_lvl);
endinterface : micf_arb_if

/* rtl/micf_req_sync.sv */
module micf_req_sync
  import micf_pkg::*;
#(
  parameter int W = NSRC
) (
  input wire logic clk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic [W-1:0] req_in, // raw request lines
  output logic [W-1:0] req_rise // one-cycle pulse per rising edge
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // ---------------------------------------------------------------
  // two-stage synchroniser, edge taken after the second stage
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= req_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a held line counts once; it must drop before it can request again
  assign req_rise = s2_q & ~s3_q;
endmodule : micf_req_sync

/* rtl/micf_arbiter.sv */
module micf_arbiter
  import micf_pkg::*;
(
  micf_arb_if.arb arb // eligible requests in, winner out
);
  // ---------------------------------------------------------------
  // lowest level wins, ties go to the lowest default rank
  // ---------------------------------------------------------------
  always_comb begin
    arb.win_valid = 1'b0;
    arb.win_id = '0;
    arb.win_lvl = PR_RST;
    // scanning downward with <= lets lower ranks take over equal levels
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (arb.elig[i] && (!arb.win_valid || arb.lvl[i] <= arb.win_lvl)) begin
        arb.win_valid = 1'b1;
        arb.win_id = ID_W'(i);
        arb.win_lvl = arb.lvl[i];
      end
    end
  end
endmodule : micf_arbiter

/* verification/micf_top_asserts.sv */
module micf_top_asserts
  import micf_pkg::*;
(
  input wire logic REF_CLK, // clock
  input wire logic ARST_N, // reset
  input wire logic HSEL, // select
  input wire logic [ADDR_W-1:0] HADDR, // address
  input wire logic [1:0] HTRANS, // type
  input wire logic HWRITE, // write
  input wire logic HREADY, // ready in
  input wire logic [31:0] HRDATA, // read data
  input wire logic INT_VALID, // offer
  input wire logic [ID_W-1:0] INT_ID, // offered rank
  input wire logic [1:0] INT_LEVEL, // its level
  input wire logic INT_MACRO, // macro service
  input wire logic INT_CTX, // context switch
  input wire logic INT_ACK, // core ack
  input wire logic MACRO_END, // macro end
  input wire logic IRQ // event irq
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  logic rd_q;
  logic [ADDR_W-1:0] ra_q;
  logic wr_now;
  assign wr_now = HSEL && HTRANS[1] && HWRITE;
  // remember which word the data phase returns
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_q <= 1'b0;
      ra_q <= '0;
    end else begin
      rd_q <= HSEL && HTRANS[1] && HREADY && !HWRITE;
      ra_q <= HADDR;
    end
  end
  a_reset_state: assert property ($rose(ARST_N) |-> !INT_VALID && INT_LEVEL == 2'h3 && !IRQ)
    else $error("offer or irq wrong after reset");
  a_ack_drop: assert property (INT_VALID && INT_ACK |=> !INT_VALID)
    else $error("offer stays after ack");
  a_mode_excl: assert property (INT_VALID && INT_MACRO |-> !INT_CTX)
    else $error("macro and context offered together");
  a_no_macro_src: assert property (INT_VALID && INT_ID inside {5'h0E, 5'h12} |-> !INT_MACRO)
    else $error("macro offered on source without it");
  a_id_range: assert property (INT_VALID |-> INT_ID < NSRC)
    else $error("offered rank out of range");
  a_ctrl_rsvd: assert property (rd_q && ra_q <= CTRL_LAST_OFS |->
    HRDATA[31:8] == 24'h0 && HRDATA[3:2] == 2'h0)
    else $error("control word reserved bits set");
  a_mask_width: assert property (rd_q && ra_q == MASK_HI_OFS |-> HRDATA[31:9] == 23'h0)
    else $error("mask high word too wide");
  // a write lands one cycle after its address phase and reaches the offer one
  // cycle later; without it only a fresh, better request may replace the offer
  a_offer_hold: assert property (INT_VALID && !INT_ACK && !wr_now && !$past(wr_now)
    && !$past(wr_now, 2) |=> INT_VALID && (INT_LEVEL < $past(INT_LEVEL)
    || (INT_LEVEL == $past(INT_LEVEL) && INT_ID <= $past(INT_ID))))
    else $error("offer changed without ack");
  c_ack: cover property (INT_VALID && INT_ACK);
  c_macro: cover property (INT_VALID && INT_MACRO && INT_ACK);
  c_ctx: cover property (INT_VALID && INT_CTX && INT_ACK);
  c_mend: cover property (MACRO_END);
endmodule : micf_top_asserts

bind micf_top micf_top_asserts u_micf_top_asserts (.REF_CLK, .ARST_N, .HSEL, .HADDR, .HTRANS,
  .HWRITE, .HREADY, .HRDATA, .INT_VALID, .INT_ID, .INT_LEVEL, .INT_MACRO, .INT_CTX,
  .INT_ACK, .MACRO_END, .IRQ);

/* verification/micf_core_model.sv */
module micf_core_model
  import micf_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic int_valid, // offer present
  input wire logic [ID_W-1:0] int_id, // offered rank
  input wire logic int_macro, // offer by macro transfer
  input wire logic ack_on, // take offers at all
  input wire logic [3:0] ack_wait, // cycles to sit on an offer
  output logic int_ack, // take the offer
  output logic macro_end, // macro counter hit zero
  output logic [ID_W-1:0] macro_end_id // its source
);
  logic [3:0] wait_q;
  // a one-word macro transfer: its counter runs out right after the ack
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_ack <= 1'b0;
      wait_q <= 4'h0;
      macro_end <= 1'b0;
      macro_end_id <= '0;
    end else begin
      int_ack <= 1'b0;
      macro_end <= 1'b0;
      macro_end_id <= ~macro_end_id;
      if (int_valid && int_ack && int_macro) begin
        macro_end <= 1'b1;
        macro_end_id <= int_id;
      end
      if (int_valid && !int_ack && ack_on) begin
        wait_q <= (wait_q == ack_wait) ? 4'h0 : wait_q + 4'h1;
        int_ack <= (wait_q == ack_wait);
      end
    end
  end
endmodule : micf_core_model

/* verification/micf_top_bench.sv */
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module micf_top_bench
  import micf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, arst_n, hsel, hwrite, hreadyout, hresp, irq, ack_on;
  logic int_valid, int_macro, int_ctx, int_ack, macro_end;
  logic [ADDR_W-1:0] haddr;
  logic [1:0] htrans, int_level;
  logic [31:0] hwdata, hrdata;
  logic [NSRC-1:0] src_req;
  logic [ID_W-1:0] int_id, macro_end_id;
  logic [3:0] ack_wait;
  logic [6:0] taken[$];
  logic [6:0] exp_t[7] = '{7'h07, 7'h09, 7'h03, 7'h01, 7'h45, 7'h26, 7'h2E};
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  micf_top u_micf_top (.REF_CLK(clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata), .SRC_REQ(src_req),
    .INT_VALID(int_valid), .INT_ID(int_id), .INT_LEVEL(int_level), .INT_MACRO(int_macro),
    .INT_CTX(int_ctx), .INT_ACK(int_ack), .MACRO_END(macro_end),
    .MACRO_END_ID(macro_end_id), .IRQ(irq));
  micf_core_model u_micf_core_model (.clk(clk), .rst_n(arst_n), .int_valid(int_valid),
    .int_id(int_id), .int_macro(int_macro), .ack_on(ack_on), .ack_wait(ack_wait),
    .int_ack(int_ack), .macro_end(macro_end), .macro_end_id(macro_end_id));
  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (int_valid === 1'b1 && int_ack === 1'b1) taken.push_back({int_macro, int_ctx, int_id});
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
  // -------------------------------------------------------------
  // bus tasks, entered just after a rising edge
  // -------------------------------------------------------------
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(q, e)
    `CHK(hresp, 1'b0)
  endtask : rd
  task automatic wait_n(input int n);
    for (int k = 0; k < 300 && taken.size() < n; k++) @(posedge clk);
    `CHK(taken.size(), n)
  endtask : wait_n
  task automatic complete_run();
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    clk = 0;
    arst_n = 0;
    hsel = 0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 0;
    hwdata = 32'h0;
    src_req = '0;
    ack_on = 0;
    ack_wait = 4'h0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < NSRC; i++) rd(12'(4 * i), 32'h43);
    rd(MASK_LO_OFS, 32'hFFFF);
    rd(MASK_HI_OFS, 32'h1FF);
    rd(12'h0A0, 32'h0);
    for (int i = 0; i < NSRC; i++) wr(12'(4 * i), 32'h30 | 32'(i % 4));
    for (int i = 0; i < NSRC; i++) rd(12'(4 * i), ((i == 14 || i == 18) ? 32'h10 : 32'h30)
      | 32'(i % 4));
    rd(MASK_LO_OFS, 32'h0);
    wr(MASK_HI_OFS, 32'h1FF);
    wr(MASK_LO_OFS, 32'hFFFF);
    rd(12'h00C, 32'h73);
    wr(12'h004, 32'h40);
    wr(12'h00C, 32'h02);
    wr(12'h01C, 32'h01);
    wr(12'h024, 32'h01);
    src_req <= 25'h000028A;
    repeat (8) @(posedge clk);
    `CHK({int_valid, int_id, int_level}, {1'b1, 5'h07, 2'h1})
    rd(SVC_STAT_OFS, 32'h80000027);
    rd(12'h004, 32'hC0);
    rd(MASK_LO_OFS, 32'hFD77);
    ack_on <= 1'b1;
    wait_n(3);
    rd(12'h01C, 32'h01);
    rd(EV_STAT_OFS, 32'h1);
    wr(EV_EN_OFS, 32'h2);
    @(posedge clk);
    `CHK(irq, 1'b0)
    wr(EV_EN_OFS, 32'h3);
    @(posedge clk);
    `CHK(irq, 1'b1)
    rd(EV_EN_OFS, 32'h3);
    wr(EV_CLR_OFS, 32'h1);
    @(posedge clk);
    `CHK(irq, 1'b0)
    wr(12'h004, 32'h80);
    wait_n(4);
    src_req <= '0;
    ack_wait <= 4'h3;
    wr(12'h014, 32'h20);
    wr(12'h018, 32'h10);
    wr(12'h038, 32'h30);
    src_req <= 25'h0004060;
    wait_n(7);
    for (int k = 0; k < 7; k++) `CHK(taken[k], exp_t[k])
    rd(12'h014, 32'h00);
    rd(EV_STAT_OFS, 32'h3);
    complete_run();
  end
endmodule : micf_top_bench
